// ===== sweep_seq_pkg.sv
// Purpose: shared constants and types of the sweep step timing sequencer
// Assumes: 10 MHz clk_sys; all intervals count in 0.1 ms ticks
// Notes: limits are held in tick units (hold in 10 ms units)
package sweep_seq_pkg;

  // ********************
  // clock and tick timing
  // ********************
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS = 100000; // 0.1 ms resolution
  localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_UNIT_NS = 10000000; // 10 ms hold resolution
  localparam int TW = 23; // interval counter width in ticks
  localparam logic [TW-1:0] HOLD_SCALE = TW'(HOLD_UNIT_NS / TICK_NS);

  // ********************
  // value limits (resolution units)
  // ********************
  localparam logic [31:0] HOLD_MAX = 32'h0000ffff; // 655.35 s
  localparam logic [31:0] SETTLE_MAX = 32'h0009fff6; // 65.535 s
  localparam logic [31:0] SETTLE_MAX_AC = 32'h0063ff9c; // 655.35 s
  localparam logic [31:0] GAP_MAX = 32'h00002710; // 1.0 s
  localparam logic [31:0] LAG_MAX = 32'h0009fff6; // 65.535 s
  localparam logic [31:0] STEPS_MAX = 32'h00002711; // 10001 steps
  localparam logic [31:0] STEPS_MIN = 32'h00000001;

  // ********************
  // register map
  // ********************
  localparam logic [2:0] SET_SPACE = 3'h0; // addr[7:5] of timing sets
  localparam logic [2:0] F_HOLD = 3'h0;
  localparam logic [2:0] F_SETTLE = 3'h1;
  localparam logic [2:0] F_GAP = 3'h2;
  localparam logic [2:0] F_SLAG = 3'h3;
  localparam logic [2:0] F_MLAG = 3'h4;
  localparam logic [7:0] ADDR_CTRL = 8'h20;
  localparam logic [7:0] ADDR_CMD = 8'h21;
  localparam logic [7:0] ADDR_STATUS = 8'h22;
  localparam logic [7:0] ADDR_STEPS = 8'h23;
  localparam int CMD_START = 0;
  localparam int CMD_OUT_SEQ = 1;
  localparam int CMD_WAIT = 2;
  localparam int CMD_WAIT_NEW = 3;

  // measurement mode numbers
  localparam logic [4:0] MODE_STAIR = 5'h02;
  localparam logic [4:0] MODE_MULTI = 5'h10;
  localparam logic [4:0] DC_BIAS_CV_SWEEP_MODE = 5'h12;
  localparam logic [4:0] CAP_FREQ_SWEEP_MODE = 5'h16;
  localparam logic [4:0] AC_LEVEL_CV_SWEEP_MODE = 5'h17;
  localparam logic [1:0] THIRD_TRIGGER_MODE = 2'h2; // modes 1..4 as 0..3

  typedef enum logic [1:0] {SET_STAIR, SET_ACV, SET_DCV, SET_CF} set_sel_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_HOLD, ST_SETTLE, ST_TRIG, ST_MLAG, ST_MEAS, ST_WAITX
  } seq_state_t;

  typedef struct packed {
    logic [15:0] hold;
    logic [TW-1:0] settle;
    logic [13:0] gap;
    logic [19:0] srcLag;
    logic [19:0] measLag;
  } timing_t;

  typedef struct packed {
    logic useMeasTrig;
    logic [1:0] trigMode;
    logic [4:0] measMode;
  } ctrl_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } bus_req_t;

endpackage : sweep_seq_pkg

// ===== pin_sync.sv
// Purpose: two-stage synchroniser with rising edge detect for a pin
// Assumes: pin is asynchronous to clk_sys
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // pin and result
  input wire logic pinIn,
  output logic rise
);

  logic meta;
  logic stable;
  logic prev;

  // ********************
  // synchroniser stages
  // ********************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta <= 1'b0;
      stable <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pinIn;
      stable <= meta;
      prev <= stable;
    end
  end

  // edge seen only after both stages
  assign rise = stable && !prev;

endmodule : pin_sync
`default_nettype wire

// ===== interval_timer.sv
// Purpose: loadable down counter of 0.1 ms ticks
// Assumes: load restarts the sub-tick divider, so intervals are exact
// Notes: expired is high whenever the count is zero
`timescale 1ns/1ps
`default_nettype none
module interval_timer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // load port
  input wire logic load,
  input wire logic [sweep_seq_pkg::TW-1:0] loadVal,
  // status
  output logic expired
);

  localparam int SW = $clog2(sweep_seq_pkg::TICK_CYC);
  localparam logic [SW-1:0] SUB_LAST = SW'(sweep_seq_pkg::TICK_CYC - 1);

  logic [SW-1:0] sub;
  logic [sweep_seq_pkg::TW-1:0] cnt;
  logic tickEnd;

  // ********************
  // tick divider and count
  // ********************
  assign tickEnd = (sub == SUB_LAST);
  assign expired = (cnt == '0);

  // divider only runs while counting, keeping phase tied to load
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sub <= '0;
      cnt <= '0;
    end else if (load) begin
      sub <= '0;
      cnt <= loadVal;
    end else if (!expired) begin
      sub <= tickEnd ? '0 : sub + 1'b1;
      if (tickEnd) begin
        cnt <= cnt - 1'b1;
      end
    end
  end

  a_load_takes: assert property (
    @(posedge clk_sys) disable iff (srst)
    load |=> cnt == $past(loadVal) && sub == '0)
    else $error("timer did not take load value");

endmodule : interval_timer
`default_nettype wire

// ===== sweep_step_timing_sequencer.sv
// Purpose: hold, settle, gap and trigger lag sequencing of swept steps
// Assumes: setupComplete and measDone come from logic on clk_sys
// Notes: four timing sets, chosen by measurement mode
// Behaviour
// - hold interval before first step settle
// - settle between forcing step and measurement
// - gap from measurement start to next force
// - late measurement delays next force until done
// - source lag before setup complete trigger
// - measurement lag after start trigger
// - omitted optional values become zero
// - never programmed sets hold all zeros
// - staircase set unused by pulsed modes
// - AC level set: longer settle, limited lag
// - DC bias mode keeps own set
// - C-f mode keeps own set
// - trigger flag cleared in four cases
// - wait mode 1 uses flag, 2 waits new
`timescale 1ns/1ps
`default_nettype none
module sweep_step_timing_sequencer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // register port
  input wire sweep_seq_pkg::bus_req_t busReq,
  output logic [31:0] rdata,
  // trigger pin and source/measure handshakes
  input wire logic trigIn,
  input wire logic setupComplete,
  input wire logic measDone,
  // step outputs
  output logic forceStep,
  output logic setupDoneTrig,
  output logic measStart,
  output logic sweepDone,
  output logic waiting
);

  function automatic logic [31:0] clampVal(input logic [31:0] v,
                                           input logic [31:0] lim);
    clampVal = (v > lim) ? lim : v;
  endfunction : clampVal

  sweep_seq_pkg::timing_t sets [4];
  sweep_seq_pkg::timing_t active;
  sweep_seq_pkg::ctrl_t ctrl;
  sweep_seq_pkg::ctrl_t newCtrl;
  sweep_seq_pkg::seq_state_t state;
  sweep_seq_pkg::seq_state_t next_state;
  sweep_seq_pkg::set_sel_t setIdx;
  logic setValid;
  logic trigFlag;
  logic next_trigFlag;
  logic waitNew;
  logic srcPend;
  logic srcArmed;
  logic measFinished;
  logic [13:0] numSteps;
  logic [13:0] stepsLeft;
  logic trigEdge;
  logic mainExp;
  logic srcExp;
  logic loadMain;
  logic [sweep_seq_pkg::TW-1:0] mainVal;
  logic next_force;
  logic next_meas;
  logic next_done;
  logic consumeTrig;
  logic endWait;
  logic [31:0] readMux;
  logic [31:0] settleLim;
  logic [31:0] slagLim;

  // ********************
  // register decode
  // ********************
  wire logic [1:0] wrSet = busReq.addr[4:3];
  wire logic [2:0] wrField = busReq.addr[2:0];
  wire logic setWr = busReq.wr
    && (busReq.addr[7:5] == sweep_seq_pkg::SET_SPACE);
  wire logic ctrlWr = busReq.wr && (busReq.addr == sweep_seq_pkg::ADDR_CTRL);
  wire logic cmdWr = busReq.wr && (busReq.addr == sweep_seq_pkg::ADDR_CMD);
  wire logic stepsWr = busReq.wr && (busReq.addr == sweep_seq_pkg::ADDR_STEPS);
  wire logic startCmd = cmdWr && busReq.wdata[sweep_seq_pkg::CMD_START];
  wire logic osCmd = cmdWr && busReq.wdata[sweep_seq_pkg::CMD_OUT_SEQ];
  wire logic waitCmd = cmdWr && busReq.wdata[sweep_seq_pkg::CMD_WAIT];
  wire logic leaveThird = ctrlWr
    && (ctrl.trigMode == sweep_seq_pkg::THIRD_TRIGGER_MODE)
    && (newCtrl.trigMode != sweep_seq_pkg::THIRD_TRIGGER_MODE);
  wire logic srcLoad = srcPend && setupComplete;

  assign newCtrl = sweep_seq_pkg::ctrl_t'(busReq.wdata[7:0]);
  // the AC level set allows a ten times longer settle
  assign settleLim = (wrSet == 2'(sweep_seq_pkg::SET_ACV))
    ? sweep_seq_pkg::SETTLE_MAX_AC : sweep_seq_pkg::SETTLE_MAX;
  // source lag may not exceed its own set's settle interval
  assign slagLim = clampVal(32'(sets[wrSet].settle),
                            sweep_seq_pkg::LAG_MAX);

  // ********************
  // set selection by measurement mode
  // ********************
  always_comb begin
    setValid = 1'b1;
    setIdx = sweep_seq_pkg::SET_STAIR;
    case (ctrl.measMode)
      sweep_seq_pkg::MODE_STAIR,
      sweep_seq_pkg::MODE_MULTI: setIdx = sweep_seq_pkg::SET_STAIR;
      sweep_seq_pkg::AC_LEVEL_CV_SWEEP_MODE: setIdx = sweep_seq_pkg::SET_ACV;
      sweep_seq_pkg::DC_BIAS_CV_SWEEP_MODE:
        setIdx = sweep_seq_pkg::SET_DCV;
      sweep_seq_pkg::CAP_FREQ_SWEEP_MODE:
        setIdx = sweep_seq_pkg::SET_CF;
      default: setValid = 1'b0;
    endcase
  end

  // pulsed and other modes run with zero delays
  assign active = setValid ? sets[setIdx] : '0;

  // ********************
  // timing set registers
  // ********************
  // a hold write opens a new timing command and zeroes optionals
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < 4; i++) begin
        sets[i] <= '0;
      end
    end else if (setWr) begin
      case (wrField)
        sweep_seq_pkg::F_HOLD: begin
          sets[wrSet].hold <= 16'(clampVal(busReq.wdata,
                                           sweep_seq_pkg::HOLD_MAX));
          sets[wrSet].gap <= '0;
          sets[wrSet].srcLag <= '0;
          sets[wrSet].measLag <= '0;
        end
        sweep_seq_pkg::F_SETTLE:
          sets[wrSet].settle <= sweep_seq_pkg::TW'(
            clampVal(busReq.wdata, settleLim));
        sweep_seq_pkg::F_GAP:
          sets[wrSet].gap <= 14'(clampVal(busReq.wdata,
                                          sweep_seq_pkg::GAP_MAX));
        sweep_seq_pkg::F_SLAG:
          sets[wrSet].srcLag <= 20'(clampVal(busReq.wdata, slagLim));
        sweep_seq_pkg::F_MLAG:
          sets[wrSet].measLag <= 20'(clampVal(busReq.wdata,
                                              sweep_seq_pkg::LAG_MAX));
        default: ;
      endcase
    end
  end

  // ********************
  // control registers
  // ********************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl <= '0;
      numSteps <= 14'(sweep_seq_pkg::STEPS_MIN);
    end else begin
      if (ctrlWr) begin
        ctrl <= newCtrl;
      end
      if (stepsWr) begin
        numSteps <= 14'(clampVal(busReq.wdata | 32'(busReq.wdata == '0),
                                 sweep_seq_pkg::STEPS_MAX));
      end
    end
  end

  // ********************
  // trigger pin and timers
  // ********************
  pin_sync uTrigSync (
    .clk_sys(clk_sys),
    .srst(srst),
    .pinIn(trigIn),
    .rise(trigEdge)
  );

  interval_timer uMainTimer (
    .clk_sys(clk_sys),
    .srst(srst),
    .load(loadMain),
    .loadVal(mainVal),
    .expired(mainExp)
  );

  interval_timer uSrcTimer (
    .clk_sys(clk_sys),
    .srst(srst),
    .load(srcLoad),
    .loadVal(sweep_seq_pkg::TW'(active.srcLag)),
    .expired(srcExp)
  );

  // new trigger wins over any clear in the same cycle, except the edge
  // that itself ends a mode 2 wait: that edge is used up by the wait
  assign next_trigFlag = (trigEdge && !(endWait && waitNew))
                         || (trigFlag && !(leaveThird || osCmd
                         || consumeTrig || endWait));

  // ********************
  // step sequence
  // ********************
  always_comb begin
    next_state = state;
    loadMain = 1'b0;
    mainVal = '0;
    next_force = 1'b0;
    next_meas = 1'b0;
    next_done = 1'b0;
    consumeTrig = 1'b0;
    endWait = 1'b0;
    case (state)
      sweep_seq_pkg::ST_IDLE: begin
        if (startCmd) begin
          next_state = sweep_seq_pkg::ST_HOLD;
          loadMain = 1'b1;
          mainVal = sweep_seq_pkg::TW'(active.hold
                    * sweep_seq_pkg::HOLD_SCALE);
        end else if (waitCmd) begin
          next_state = sweep_seq_pkg::ST_WAITX;
        end
      end
      sweep_seq_pkg::ST_HOLD: begin
        if (mainExp) begin
          next_force = 1'b1;
        end
      end
      sweep_seq_pkg::ST_SETTLE: begin
        if (mainExp && ctrl.useMeasTrig) begin
          next_state = sweep_seq_pkg::ST_TRIG;
        end else if (mainExp) begin
          next_meas = 1'b1;
        end
      end
      sweep_seq_pkg::ST_TRIG: begin
        if (trigFlag) begin
          consumeTrig = 1'b1;
          next_state = sweep_seq_pkg::ST_MLAG;
          loadMain = 1'b1;
          mainVal = sweep_seq_pkg::TW'(active.measLag);
        end
      end
      sweep_seq_pkg::ST_MLAG: begin
        if (mainExp) begin
          next_meas = 1'b1;
        end
      end
      sweep_seq_pkg::ST_MEAS: begin
        // gap alone is not enough: the measurement must have ended
        if (mainExp && (measFinished || measDone)) begin
          if (stepsLeft == '0) begin
            next_done = 1'b1;
            next_state = sweep_seq_pkg::ST_IDLE;
          end else begin
            next_force = 1'b1;
          end
        end
      end
      sweep_seq_pkg::ST_WAITX: begin
        if (waitNew ? trigEdge : trigFlag) begin
          endWait = 1'b1;
          next_state = sweep_seq_pkg::ST_IDLE;
        end
      end
      default: next_state = sweep_seq_pkg::ST_IDLE;
    endcase
    if (next_force) begin
      next_state = sweep_seq_pkg::ST_SETTLE;
      loadMain = 1'b1;
      mainVal = active.settle;
    end
    if (next_meas) begin
      next_state = sweep_seq_pkg::ST_MEAS;
      loadMain = 1'b1;
      mainVal = sweep_seq_pkg::TW'(active.gap);
    end
  end

  // ********************
  // sequence state
  // ********************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= sweep_seq_pkg::ST_IDLE;
      trigFlag <= 1'b0;
      waitNew <= 1'b0;
      stepsLeft <= '0;
      measFinished <= 1'b0;
    end else begin
      state <= next_state;
      trigFlag <= next_trigFlag;
      if (waitCmd && state == sweep_seq_pkg::ST_IDLE) begin
        waitNew <= busReq.wdata[sweep_seq_pkg::CMD_WAIT_NEW];
      end
      if (startCmd && state == sweep_seq_pkg::ST_IDLE) begin
        stepsLeft <= numSteps;
      end else if (next_force) begin
        stepsLeft <= stepsLeft - 1'b1;
      end
      measFinished <= next_meas ? 1'b0 : (measFinished || measDone);
    end
  end

  // ********************
  // source lag and step outputs
  // ********************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      srcPend <= 1'b0;
      srcArmed <= 1'b0;
      forceStep <= 1'b0;
      setupDoneTrig <= 1'b0;
      measStart <= 1'b0;
      sweepDone <= 1'b0;
      waiting <= 1'b0;
    end else begin
      srcPend <= next_force || (srcPend && !setupComplete);
      srcArmed <= srcLoad || (srcArmed && !srcExp);
      setupDoneTrig <= srcArmed && srcExp;
      forceStep <= next_force;
      measStart <= next_meas;
      sweepDone <= next_done;
      waiting <= (next_state == sweep_seq_pkg::ST_WAITX)
                 || (next_state == sweep_seq_pkg::ST_TRIG);
    end
  end

  // ********************
  // read path
  // ********************
  always_comb begin
    readMux = '0;
    if (busReq.addr[7:5] == sweep_seq_pkg::SET_SPACE) begin
      case (wrField)
        sweep_seq_pkg::F_HOLD: readMux = 32'(sets[wrSet].hold);
        sweep_seq_pkg::F_SETTLE: readMux = 32'(sets[wrSet].settle);
        sweep_seq_pkg::F_GAP: readMux = 32'(sets[wrSet].gap);
        sweep_seq_pkg::F_SLAG: readMux = 32'(sets[wrSet].srcLag);
        sweep_seq_pkg::F_MLAG: readMux = 32'(sets[wrSet].measLag);
        default: readMux = '0;
      endcase
    end else begin
      case (busReq.addr)
        sweep_seq_pkg::ADDR_CTRL: readMux = 32'(ctrl);
        sweep_seq_pkg::ADDR_STATUS:
          readMux = {16'(stepsLeft), 10'h000, setValid, trigFlag,
                     1'b0, 3'(state)};
        sweep_seq_pkg::ADDR_STEPS: readMux = 32'(numSteps);
        default: readMux = '0;
      endcase
    end
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata <= '0;
    end else begin
      rdata <= busReq.rd ? readMux : '0;
    end
  end

  // ********************
  // checks
  // ********************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence sHoldStart;
    state == sweep_seq_pkg::ST_IDLE && startCmd;
  endsequence
  sequence sHoldRunning;
    state == sweep_seq_pkg::ST_HOLD && !mainExp;
  endsequence

  a_hold_entry: assert property (
    sHoldStart |=> state == sweep_seq_pkg::ST_HOLD && !forceStep)
    else $error("hold not entered on start");
  a_hold_no_force: assert property (sHoldRunning |=> !forceStep)
    else $error("step forced during hold");
  a_force_settle: assert property (
    forceStep |-> state == sweep_seq_pkg::ST_SETTLE && !measStart)
    else $error("force without settle");
  a_meas_after_lag: assert property (
    measStart |-> $past(mainExp) && ($past(state) == sweep_seq_pkg::ST_SETTLE
    || $past(state) == sweep_seq_pkg::ST_MLAG))
    else $error("measurement started early");
  a_gap_holds: assert property (
    state == sweep_seq_pkg::ST_MEAS && !measFinished && !measDone
    |=> !forceStep)
    else $error("next step forced before measurement end");
  a_src_trig: assert property (
    setupDoneTrig |-> $past(srcArmed) && $past(srcExp))
    else $error("setup trigger without lag expiry");
  a_os_clears: assert property (osCmd && !trigEdge |=> !trigFlag)
    else $error("flag not cleared by output sequence");
  a_edge_sets: assert property (
    trigEdge && !(endWait && waitNew) |=> trigFlag)
    else $error("trigger edge lost");
  a_wait_clears: assert property (
    endWait && (waitNew || !trigEdge) |=> !trigFlag)
    else $error("flag not cleared at end of wait");
  a_wait_one: assert property (
    state == sweep_seq_pkg::ST_WAITX && !waitNew && trigFlag
    |=> state == sweep_seq_pkg::ST_IDLE)
    else $error("wait mode 1 ignored stored flag");
  a_optional_zero: assert property (
    setWr && wrField == sweep_seq_pkg::F_HOLD
    |=> sets[$past(wrSet)].gap == '0 && sets[$past(wrSet)].measLag == '0)
    else $error("optional values not zeroed");
  a_pulsed_zero: assert property (!setValid |-> active == '0)
    else $error("pulsed mode used a timing set");

endmodule : sweep_step_timing_sequencer
`default_nettype wire

// ===== sweep_partner.sv
// Purpose: far side handshakes of the step sequencer
// Assumes: one clk_sys domain, pulses one cycle long
// Notes: measurement time is set by measDly, at least 1
`timescale 1ns/1ps
`default_nettype none
module sweep_partner (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // from sequencer
  input wire logic forceStep,
  input wire logic measStart,
  input wire logic [15:0] measDly,
  // to sequencer
  output logic setupComplete,
  output logic measDone
);
  int sc;
  int mc;
  // setup ends 3 cycles after force, measurement measDly after start
  always_ff @(posedge clk_sys) begin
    sc <= srst ? 0 : forceStep ? 3 : (sc > 0 ? sc - 1 : 0);
    mc <= srst ? 0 : measStart ? int'(measDly) : (mc > 0 ? mc - 1 : 0);
    setupComplete <= (sc == 1);
    measDone <= (mc == 1); // a slow done must hold off the next step
  end
endmodule : sweep_partner
`default_nettype wire

// ===== sweep_step_timing_sequencer_test.sv
// Purpose: self-checking bench of the step sequencer
// Assumes: tick of 1000 cycles, hold unit far too long to run
// Notes: pulse times are taken by a monitor in cycles
`timescale 1ns/1ps
`default_nettype none
module sweep_step_timing_sequencer_test;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  sweep_seq_pkg::bus_req_t busReq = '0;
  logic [31:0] rdata;
  logic trigIn = 1'b0;
  logic setupComplete, measDone, forceStep, setupDoneTrig;
  logic measStart, sweepDone, waiting;
  logic [15:0] measDly = 16'h0002;
  logic [31:0] r;
  logic [4:0] md [6] = '{sweep_seq_pkg::MODE_STAIR,
    sweep_seq_pkg::MODE_MULTI, sweep_seq_pkg::AC_LEVEL_CV_SWEEP_MODE,
    sweep_seq_pkg::DC_BIAS_CV_SWEEP_MODE,
    sweep_seq_pkg::CAP_FREQ_SWEEP_MODE, 5'h04};
  int ex [6] = '{1, 1, 2, 3, 4, 0};
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int nDone = 0;
  int tF, tP, tM, tS, tD, tQ, tT, tC, lo;
  always #50 clk_sys = ~clk_sys;
  sweep_step_timing_sequencer u_dut (.clk_sys(clk_sys), .srst(srst),
    .busReq(busReq), .rdata(rdata), .trigIn(trigIn),
    .setupComplete(setupComplete), .measDone(measDone),
    .forceStep(forceStep), .setupDoneTrig(setupDoneTrig),
    .measStart(measStart), .sweepDone(sweepDone), .waiting(waiting));
  sweep_partner u_far (.clk_sys(clk_sys), .srst(srst),
    .forceStep(forceStep), .measStart(measStart), .measDly(measDly),
    .setupComplete(setupComplete), .measDone(measDone));
  // pulse monitor, cycle stamps of the latest events
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (forceStep === 1'b1) begin
      tP <= tF;
      tF <= cyc;
    end
    if (measStart === 1'b1) tM <= cyc;
    if (setupDoneTrig === 1'b1) tS <= cyc;
    // previous done kept, a later step's done must not hide it
    if (measDone === 1'b1) begin
      tQ <= tD;
      tD <= cyc;
    end
    if (sweepDone === 1'b1) nDone <= nDone + 1;
  end
  // ****************
  // bus and compare tasks
  // ****************
  task check_eq(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask : check_eq
  task check_rng(input int g, input int lo, input int hi);
    check_count++;
    if (g < lo || g > hi) begin
      num_errors++;
      $display("mismatch %0t span %0d not in %0d..%0d", $time, g, lo, hi);
    end
  endtask : check_rng
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    busReq <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    busReq <= '0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a);
    @(posedge clk_sys);
    busReq <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clk_sys);
    busReq <= '0;
    #1 r = rdata;
  endtask : rd
  // hold first, since a hold write clears the optionals
  task prog(input logic [1:0] s, input logic [31:0] st, input logic [31:0] g,
            input logic [31:0] sl, input logic [31:0] ml);
    wr({3'h0, s, sweep_seq_pkg::F_HOLD}, 32'h0);
    wr({3'h0, s, sweep_seq_pkg::F_SETTLE}, st);
    wr({3'h0, s, sweep_seq_pkg::F_GAP}, g);
    wr({3'h0, s, sweep_seq_pkg::F_SLAG}, sl);
    wr({3'h0, s, sweep_seq_pkg::F_MLAG}, ml);
  endtask : prog
  task run(input logic [7:0] c, input logic [31:0] n);
    wr(sweep_seq_pkg::ADDR_CTRL, {24'h0, c});
    wr(sweep_seq_pkg::ADDR_STEPS, n);
    wr(sweep_seq_pkg::ADDR_CMD, 32'h1);
    #1 tC = cyc;
  endtask : run
  task wait_done;
    int d0;
    d0 = nDone;
    for (int i = 0; i < 30000 && nDone == d0; i++) @(posedge clk_sys);
    check_eq(32'(nDone != d0), 32'h1);
  endtask : wait_done
  task pulse;
    @(posedge clk_sys);
    trigIn <= 1'b1;
    tT = cyc;
    repeat (4) @(posedge clk_sys);
    trigIn <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : pulse
  task stat(input logic [3:0] e);
    rd(sweep_seq_pkg::ADDR_STATUS);
    check_eq({28'h0, r[4], r[2:0]}, {28'h0, e});
  endtask : stat
  task finish_test;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  // watchdog, about twice the expected run of some 33000 cycles
  initial begin
    #6000000;
    num_errors++;
    finish_test();
  end
  // main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    for (int i = 0; i < 32; i++) begin
      rd(8'(i));
      check_eq(r, 32'h0);
    end
    rd(sweep_seq_pkg::ADDR_STEPS);
    check_eq(r, 32'h1);
    rd(8'h40);
    check_eq(r, 32'h0);
    wr(8'h02, 32'hffff);
    rd(8'h02);
    check_eq(r, sweep_seq_pkg::GAP_MAX);
    wr(8'h00, 32'hffffffff);
    rd(8'h02);
    check_eq(r, 32'h0);
    rd(8'h00);
    check_eq(r, sweep_seq_pkg::HOLD_MAX);
    wr(8'h01, 32'hffffffff);
    rd(8'h01);
    check_eq(r, sweep_seq_pkg::SETTLE_MAX);
    wr(8'h09, 32'hffffffff);
    wr(8'h0b, 32'hffffffff);
    rd(8'h09);
    check_eq(r, sweep_seq_pkg::SETTLE_MAX_AC);
    rd(8'h0b);
    check_eq(r, sweep_seq_pkg::LAG_MAX);
    wr(8'h01, 32'h2);
    wr(8'h03, 32'h5);
    rd(8'h03);
    check_eq(r, 32'h2);
    wr(8'h04, 32'hffffffff);
    rd(8'h04);
    check_eq(r, sweep_seq_pkg::LAG_MAX);
    // each mode picks its set (multi shares the staircase set), pulsed mode none
    for (int s = 0; s < 4; s++) prog(2'(s), 32'(s + 1), 0, 0, 0);
    for (int k = 0; k < 6; k++) begin
      run({3'h0, md[k]}, 32'h1);
      wait_done();
      lo = ex[k] * sweep_seq_pkg::TICK_CYC;
      check_rng(tF - tC, 0, 4);
      check_rng(tM - tF, lo, lo + 3);
    end
    prog(2'h0, 32'h1, 32'h2, 32'h1, 32'h0);
    run(8'h02, 32'h2);
    wait_done();
    check_rng(tF - tP, 3000, 3006);
    check_rng(tS - tF, 1003, 1008);
    measDly <= 16'd5000;
    run(8'h02, 32'h2);
    wait_done();
    check_rng(tF - tQ, 0, 3);
    measDly <= 16'h0002;
    // trigger driven measurement in the third mode
    prog(2'h0, 32'h1, 32'h0, 32'h0, 32'h2);
    wr(sweep_seq_pkg::ADDR_CMD, 32'h2);
    run(8'hc2, 32'h1);
    for (int i = 0; i < 5000 && waiting !== 1'b1; i++) @(posedge clk_sys);
    check_eq({31'h0, waiting}, 32'h1);
    pulse();
    wait_done();
    check_rng(tM - tT, 2000, 2008);
    stat(4'h0);
    pulse();
    stat(4'h8);
    wr(sweep_seq_pkg::ADDR_CMD, 32'h4);
    stat(4'h0);
    pulse();
    wr(sweep_seq_pkg::ADDR_CMD, 32'hc);
    stat(4'he);
    pulse();
    stat(4'h0);
    pulse();
    wr(sweep_seq_pkg::ADDR_CMD, 32'h2);
    stat(4'h0);
    pulse();
    wr(sweep_seq_pkg::ADDR_CTRL, 32'h02);
    stat(4'h0);
    finish_test();
  end
endmodule : sweep_step_timing_sequencer_test
`default_nettype wire
